// [include/diag_regs.svh]
// Constants for the drive diagnostic status block: field positions, resets, codes.
// Assumes one 250 MHz system clock; included by package and modules.
`ifndef DIAG_REGS_SVH
`define DIAG_REGS_SVH
`define DIAG_HIST_DEPTH        5
`define DIAG_OUT_COUNT         4
`define DIAG_FUNC_READY        8'h01
`define DIAG_FUNC_ENABLED      8'h02
`define DIAG_FUNC_FAULT        8'h07
`define DIAG_FUNC_WARN         8'h0B
`define DIAG_LEVEL_ALERT       4'hE
`define DIAG_LEVEL_ALARM       4'hF
`define DIAG_PROFILE_IO        6'h01
`define DIAG_MFR_SPECIFIC      2'h1
`define DIAG_RESERVED_FIELD    4'h0
`define DIAG_NUM_RESET         32'h0000_0000
`define DIAG_WORD_RESET        16'h0000
`define DIAG_CLASS_BIT_LO      12
`define DIAG_CLASS_BIT_HI      13
`define DIAG_CLASS_NONE        2'h0
`define DIAG_CLASS_ERROR       2'h1
`define DIAG_CLASS_ALERT       2'h2
`define DIAG_FLASH_NS          100000000
`define DIAG_CLK_NS            4
`define DIAG_FLASH_CYCLES      (`DIAG_FLASH_NS / `DIAG_CLK_NS)
`endif

// [include/diag_pkg.sv]
// Types for the drive diagnostic status block.
// Assumes diag_regs.svh is on the include path.
`include "diag_regs.svh"
package diag_pkg;
   typedef enum logic [2:0] {
      RUN_NO_COMM  = 3'h0,
      RUN_HOTPLUG  = 3'h1,
      RUN_LOOPBACK = 3'h2,
      RUN_APP_ERR  = 3'h3,
      RUN_MST_ERR  = 3'h4,
      RUN_COMM_ERR = 3'h5,
      RUN_IDENTIFY = 3'h6,
      RUN_APP_STOP = 3'h7
   } run_prio_t;
   typedef enum logic [1:0] {
      ERRI_IDLE  = 2'b00,
      ERRI_CLASS = 2'b01
   } err_prio_t;
   typedef enum logic [1:0] {
      DRV_IDLE      = 2'b00,
      DRV_ENABLED   = 2'b01,
      DRV_QUICKSTOP = 2'b11,
      DRV_FAULT     = 2'b10
   } drive_state_t;
endpackage

// [include/diag_hist_if.sv]
// Carrier between the diagnostic core and its error history store.
// Assumes both ends share clk_sys.
interface diag_hist_if;
   logic        push;
   logic [15:0] code;
   logic [15:0] newest_error_slot;
   logic [15:0] oldest_error_slot;
   logic [15:0] slot_rd;
   logic [2:0]  slot_sel;
   modport store (input push, code, slot_sel,
                  output newest_error_slot, oldest_error_slot, slot_rd);
   modport core  (output push, code, slot_sel,
                  input newest_error_slot, oldest_error_slot, slot_rd);
endinterface

// [rtl/diag_hist.sv]
// Five-slot error history, slot zero newest.
// Assumes push comes from the core on clk_sys; every cycle it is high shifts in one code.
`include "diag_regs.svh"
module diag_hist #(
   parameter int DEPTH = `DIAG_HIST_DEPTH
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   diag_hist_if.store hist
);
   import diag_pkg::*;
   typedef struct packed {
      logic [DEPTH-1:0][15:0] slot;
   } hist_state_t;
   hist_state_t st_r;
   hist_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (hist.push) begin
         for (int i = DEPTH - 1; i > 0; i--) begin
            st_nxt.slot[i] = st_r.slot[i-1];
         end
         st_nxt.slot[0] = hist.code;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hist.newest_error_slot = st_r.slot[0];
   assign hist.oldest_error_slot = st_r.slot[DEPTH-1];
   assign hist.slot_rd = (int'(hist.slot_sel) < DEPTH) ? st_r.slot[hist.slot_sel] : 16'h0000;

   a_hist_shift_in: assert property (@(posedge clk_sys) disable iff (!nrst)
      hist.push |=> st_r.slot[0] == $past(hist.code))
      else $error("history slot zero missed new code");
   a_hist_age_out: assert property (@(posedge clk_sys) disable iff (!nrst)
      hist.push |=> st_r.slot[1] == $past(st_r.slot[0]))
      else $error("history did not shift");
endmodule

// [rtl/diag_status.sv]
// Drive diagnostic status: indicator ranking, fault sequencing, status outputs,
// diagnostic words. Inputs from the drive's monitors are same-clock logic; the
// management-bus activity strobe arrives from a pin and is synchronised.
// Function
// - No communication and phases 0-4 show run priority 0.
// - Hot-plug phases 0-2 show run priority 1, above phases.
// - Run ranks loopback 2 up to application stopped 7, highest shown.
// - Error indicator priority 0 normally, 1 for class 1 error while sub_active is high.
// - Flash leftmost display point while management bus is active.
// - Keep five newest error numbers, slot zero newest, readable.
// - Hold most recent alert in its own readable parameter.
// - Output function 1 asserts while drive is not in Fault.
// - Output function 2 asserts only in Operation Enabled.
// - Output function 7 asserts once error detected and Fault entered.
// - Output function 11 asserts on limit, undervoltage, guard alert, stop.
// - Diagnostic number describes the highest priority active event.
// - Number bits 0-15 zero without error, else the error code.
// - Number bits 16-19 read 14 for alert, 15 for alarm.
// - Bits 20-23 reserved, 24-29 read 1, 30-31 read 1.
// - Class 1 word flags errors; forces quick stop then Fault.
// - Class 2 word flags alerts, resets to zero.
// - Diagnostic words are read only; master writes are ignored.
// - Alerts are reported only, never change the operating state.
`include "diag_regs.svh"
module diag_status #(
   parameter int FLASH_CYCLES = `DIAG_FLASH_CYCLES,
   parameter int OUTS         = `DIAG_OUT_COUNT
) (
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic                  comm_active,
   input  wire logic [2:0]            comm_phase,
   input  wire logic                  hotplug_active,
   input  wire logic                  loopback,
   input  wire logic                  app_error,
   input  wire logic                  mst_error,
   input  wire logic                  comm_error,
   input  wire logic                  identify_req,
   input  wire logic                  app_stopped,
   input  wire logic                  sub_active,
   input  wire logic                  mgmt_bus_activity,
   input  wire logic                  error_detect,
   input  wire logic [15:0]           error_code,
   input  wire logic                  alert_detect,
   input  wire logic [15:0]           alert_code,
   input  wire logic                  enable_req,
   input  wire logic                  fault_reset,
   input  wire logic                  quickstop_done,
   input  wire logic                  limit_switch,
   input  wire logic                  undervoltage,
   input  wire logic                  node_guard_alert,
   input  wire logic                  operational_stop,
   input  wire logic [OUTS-1:0][7:0]  output_function_select,
   input  wire logic                  master_wr,
   input  wire logic [2:0]            hist_sel,
   output logic [2:0]                 run_priority,
   output logic                       run_hotplug,
   output logic [1:0]                 err_priority,
   output logic                       display_point,
   output logic [OUTS-1:0]            status_out,
   output logic                       quick_stop_req,
   output logic [1:0]                 drive_state,
   output logic [15:0]                status_word,
   output logic [31:0]                diagnostic_number,
   output logic [15:0]                class1_error_diagnostic,
   output logic [15:0]                class2_alert_diagnostic,
   output logic [15:0]                newest_error_slot,
   output logic [15:0]                oldest_error_slot,
   output logic [15:0]                hist_rd,
   output logic [15:0]                last_alert_param
);
   import diag_pkg::*;

   localparam int FCW = $clog2(FLASH_CYCLES + 1);

   typedef struct packed {
      logic              act_s1;
      logic              act_s2;
      logic [FCW-1:0]    flash_cnt;
      logic              point;
      drive_state_t      drv;
      run_prio_t         run;
      logic              hot;
      err_prio_t         errp;
      logic [OUTS-1:0]   outs;
      logic              qs_req;
      logic [15:0]       status;
      logic [31:0]       diag_num;
      logic [15:0]       c1d;
      logic [15:0]       c2d;
      logic [15:0]       err_code;
      logic [15:0]       alert;
      logic [15:0]       hist_word;
   } core_state_t;

   core_state_t st_r;
   core_state_t st_nxt;
   diag_hist_if hist ();

   diag_hist #(
      .DEPTH (`DIAG_HIST_DEPTH)
   ) u_hist (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .hist    (hist)
   );

   // One function decodes output selections for every configurable output.
   function automatic logic out_func(input logic [7:0] sel, input drive_state_t d,
                                     input logic warn);
      logic r;
      r = 1'b0;
      if (sel == `DIAG_FUNC_READY) begin
         r = (d != DRV_FAULT);
      end else if (sel == `DIAG_FUNC_ENABLED) begin
         r = (d == DRV_ENABLED);
      end else if (sel == `DIAG_FUNC_FAULT) begin
         r = (d == DRV_FAULT);
      end else if (sel == `DIAG_FUNC_WARN) begin
         r = warn;
      end
      return r;
   endfunction

   logic warn_cond;
   logic error_present;
   assign warn_cond = limit_switch | undervoltage | node_guard_alert | operational_stop;
   assign error_present = (st_r.drv == DRV_FAULT) || (st_r.drv == DRV_QUICKSTOP);

   assign hist.push     = error_detect;
   assign hist.code     = error_code;
   assign hist.slot_sel = hist_sel;

   always_comb begin
      st_nxt = st_r;
      st_nxt.act_s1 = mgmt_bus_activity;
      st_nxt.act_s2 = st_r.act_s1;

      // Run indicator: highest active condition wins
      if (app_stopped) begin
         st_nxt.run = RUN_APP_STOP;
      end else if (identify_req) begin
         st_nxt.run = RUN_IDENTIFY;
      end else if (comm_error) begin
         st_nxt.run = RUN_COMM_ERR;
      end else if (mst_error) begin
         st_nxt.run = RUN_MST_ERR;
      end else if (app_error) begin
         st_nxt.run = RUN_APP_ERR;
      end else if (loopback) begin
         st_nxt.run = RUN_LOOPBACK;
      end else if (hotplug_active) begin
         st_nxt.run = RUN_HOTPLUG;
      end else begin
         st_nxt.run = RUN_NO_COMM;
      end
      st_nxt.hot = hotplug_active;

      st_nxt.errp = (sub_active && error_present) ? ERRI_CLASS : ERRI_IDLE;

      // Flash runs only while activity is seen; a dark point when idle
      if (st_r.act_s2) begin
         if (int'(st_r.flash_cnt) >= FLASH_CYCLES - 1) begin
            st_nxt.flash_cnt = '0;
            st_nxt.point     = ~st_r.point;
         end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 1'b1;
         end
      end else begin
         st_nxt.flash_cnt = '0;
         st_nxt.point     = 1'b0;
      end

      // Operating state; alerts deliberately have no path in here
      case (st_r.drv)
         DRV_IDLE: begin
            if (error_detect) begin
               st_nxt.drv = DRV_QUICKSTOP;
            end else if (enable_req) begin
               st_nxt.drv = DRV_ENABLED;
            end
         end
         DRV_ENABLED: begin
            if (error_detect) begin
               st_nxt.drv = DRV_QUICKSTOP;
            end else if (!enable_req) begin
               st_nxt.drv = DRV_IDLE;
            end
         end
         DRV_QUICKSTOP: begin
            if (quickstop_done) begin
               st_nxt.drv = DRV_FAULT;
            end
         end
         DRV_FAULT: begin
            if (fault_reset && !error_detect) begin
               st_nxt.drv = DRV_IDLE;
            end
         end
         default: begin
            st_nxt.drv = DRV_IDLE;
         end
      endcase
      st_nxt.qs_req = (st_nxt.drv == DRV_QUICKSTOP);

      // Error code held until fault reset; new error wins over the reset
      if (error_detect) begin
         st_nxt.err_code = error_code;
         st_nxt.c1d      = st_r.c1d | 16'h0001;
      end else if (fault_reset && st_r.drv == DRV_FAULT) begin
         st_nxt.err_code = 16'h0000;
         st_nxt.c1d      = `DIAG_WORD_RESET;
      end
      if (alert_detect) begin
         st_nxt.alert = alert_code;
      end
      st_nxt.c2d = warn_cond ? 16'h0001 : `DIAG_WORD_RESET;
      if (alert_detect) begin
         st_nxt.c2d = st_nxt.c2d | 16'h0002;
      end

      // Diagnostic number: an error outranks a standing alert
      if (st_nxt.err_code != 16'h0000) begin
         st_nxt.diag_num = {`DIAG_MFR_SPECIFIC, `DIAG_PROFILE_IO, `DIAG_RESERVED_FIELD,
                            `DIAG_LEVEL_ALARM, st_nxt.err_code};
      end else if (st_nxt.c2d != 16'h0000) begin
         st_nxt.diag_num = {`DIAG_MFR_SPECIFIC, `DIAG_PROFILE_IO, `DIAG_RESERVED_FIELD,
                            `DIAG_LEVEL_ALERT, 16'h0000};
      end else begin
         st_nxt.diag_num = `DIAG_NUM_RESET;
      end

      st_nxt.status = 16'h0000;
      if (st_nxt.c1d != 16'h0000) begin
         st_nxt.status[`DIAG_CLASS_BIT_HI:`DIAG_CLASS_BIT_LO] = `DIAG_CLASS_ERROR;
      end else if (st_nxt.c2d != 16'h0000) begin
         st_nxt.status[`DIAG_CLASS_BIT_HI:`DIAG_CLASS_BIT_LO] = `DIAG_CLASS_ALERT;
      end

      for (int i = 0; i < OUTS; i++) begin
         st_nxt.outs[i] = out_func(output_function_select[i], st_nxt.drv, warn_cond);
      end
      st_nxt.hist_word = hist.slot_rd;
   end

   // master_wr has no path into the state: the diagnostic words are read only
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign run_priority            = st_r.run;
   assign run_hotplug             = st_r.hot;
   assign err_priority            = st_r.errp;
   assign display_point           = st_r.point;
   assign status_out              = st_r.outs;
   assign quick_stop_req          = st_r.qs_req;
   assign drive_state             = st_r.drv;
   assign status_word             = st_r.status;
   assign diagnostic_number       = st_r.diag_num;
   assign class1_error_diagnostic = st_r.c1d;
   assign class2_alert_diagnostic = st_r.c2d;
   assign newest_error_slot       = hist.newest_error_slot;
   assign oldest_error_slot       = hist.oldest_error_slot;
   assign hist_rd                 = st_r.hist_word;
   assign last_alert_param        = st_r.alert;

   // A quick stop already under way may legally finish into Fault on the same edge
   sequence s_error_seen;
      error_detect && (st_r.drv == DRV_IDLE || st_r.drv == DRV_ENABLED);
   endsequence
   sequence s_to_quickstop;
      ##1 st_r.drv == DRV_QUICKSTOP && quick_stop_req;
   endsequence

   a_fault_quick_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_error_seen |-> s_to_quickstop)
      else $error("error did not start quick stop");
   a_alert_no_move: assert property (@(posedge clk_sys) disable iff (!nrst)
      (alert_detect && !error_detect && !enable_req && st_r.drv == DRV_IDLE)
      |=> st_r.drv == DRV_IDLE)
      else $error("alert changed operating state");
   a_run_top_prio: assert property (@(posedge clk_sys) disable iff (!nrst)
      app_stopped |=> run_priority == 3'h7)
      else $error("run indicator missed top priority");
   a_run_hotplug: assert property (@(posedge clk_sys) disable iff (!nrst)
      (hotplug_active && !loopback && !app_error && !mst_error && !comm_error
       && !identify_req && !app_stopped) |=> run_priority == 3'h1)
      else $error("hot-plug not shown at priority one");
   a_run_phase_low: assert property (@(posedge clk_sys) disable iff (!nrst)
      !(hotplug_active || loopback || app_error || mst_error || comm_error
        || identify_req || app_stopped) |=> run_priority == 3'h0)
      else $error("plain phase not at priority zero");
   a_err_ind_class: assert property (@(posedge clk_sys) disable iff (!nrst)
      (sub_active && st_r.drv == DRV_FAULT) |=> err_priority == 2'b01)
      else $error("class one error not shown");
   a_diag_fixed_bits: assert property (@(posedge clk_sys) disable iff (!nrst)
      diagnostic_number != 32'h0000_0000 |->
      diagnostic_number[31:20] == 12'h410)
      else $error("diagnostic number fixed fields wrong");
   a_diag_err_code: assert property (@(posedge clk_sys) disable iff (!nrst)
      (error_detect && error_code != 16'h0000) |=>
      diagnostic_number[15:0] == $past(error_code)
      && diagnostic_number[19:16] == 4'hF)
      else $error("diagnostic number lost error code");
   a_ready_out: assert property (@(posedge clk_sys) disable iff (!nrst)
      (output_function_select[0] == 8'h01 && st_nxt.drv == DRV_FAULT)
      |=> !status_out[0])
      else $error("ready output high in fault");
   a_enabled_out: assert property (@(posedge clk_sys) disable iff (!nrst)
      (output_function_select[1] == 8'h02) |=>
      status_out[1] == (drive_state == 2'b01))
      else $error("enabled output wrong");
   a_fault_out: assert property (@(posedge clk_sys) disable iff (!nrst)
      (output_function_select[2] == 8'h07) |=>
      status_out[2] == (drive_state == 2'b10))
      else $error("fault output wrong");
   a_warn_out: assert property (@(posedge clk_sys) disable iff (!nrst)
      (output_function_select[3] == 8'h0B && warn_cond) |=> status_out[3])
      else $error("warning output missed");
   a_class_bits: assert property (@(posedge clk_sys) disable iff (!nrst)
      class1_error_diagnostic != 16'h0000 |-> status_word[13:12] == 2'h1)
      else $error("class bits not set for error");
   a_alert_held: assert property (@(posedge clk_sys) disable iff (!nrst)
      alert_detect |=> last_alert_param == $past(alert_code))
      else $error("alert not held");
   a_class2_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!warn_cond && !alert_detect) |=> class2_alert_diagnostic == 16'h0000)
      else $error("class two word not cleared");
   a_point_dark: assert property (@(posedge clk_sys) disable iff (!nrst)
      !st_r.act_s2 |=> !display_point)
      else $error("point lit without activity");
endmodule

// [bench/master_model.sv]
// Fieldbus master model: reads history slots, may try a write.
// Assumes diag_status shares clk_sys; tasks are entered just after an edge.
module master_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] hist_rd,
   output logic             master_wr,
   output logic [2:0]       hist_sel
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      master_wr = 1'b0;
      hist_sel  = 3'h0;
   end
   // Words are read-only: a write is tried only when a scenario asks
   task automatic try_write();
      master_wr = 1'b1;
      @(posedge clk_sys);
      #1 master_wr = 1'b0;
   endtask
   // Read data lags the slot select by one registered cycle; three edges are waited before sampling
   task automatic read_slot(input logic [2:0] s, output logic [15:0] v);
      hist_sel = s;
      repeat (3) @(posedge clk_sys);
      #1 v = hist_rd;
   endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench for diag_status: ranking, outputs, fault walk, history.
// Assumes FLASH_CYCLES shrunk to 4; master_model plays the fieldbus side.
`include "diag_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic             clk_sys, nrst, comm_active, sub_active, mgmt_bus_activity;
   logic             error_detect, alert_detect, enable_req, fault_reset;
   logic             quickstop_done, master_wr, run_hotplug, display_point;
   logic             quick_stop_req, prev;
   logic [2:0]       comm_phase, hist_sel, run_priority;
   logic [6:0]       runc;
   logic [3:0]       warn, status_out;
   logic [3:0][7:0]  fsel;
   logic [1:0]       err_priority, drive_state;
   logic [15:0]      error_code, alert_code, status_word, class1_error_diagnostic;
   logic [15:0]      class2_alert_diagnostic, newest_error_slot, oldest_error_slot;
   logic [15:0]      hist_rd, last_alert_param, v;
   logic [31:0]      diagnostic_number;
   int               n_mismatch, total_checks, cyc, tog;

   diag_status #(.FLASH_CYCLES(4)) u_dut (
      .clk_sys, .nrst, .comm_active, .comm_phase, .hotplug_active(runc[0]),
      .loopback(runc[1]), .app_error(runc[2]), .mst_error(runc[3]),
      .comm_error(runc[4]), .identify_req(runc[5]), .app_stopped(runc[6]),
      .sub_active, .mgmt_bus_activity, .error_detect, .error_code, .alert_detect,
      .alert_code, .enable_req, .fault_reset, .quickstop_done,
      .limit_switch(warn[0]), .undervoltage(warn[1]), .node_guard_alert(warn[2]),
      .operational_stop(warn[3]), .output_function_select(fsel), .master_wr,
      .hist_sel, .run_priority, .run_hotplug, .err_priority, .display_point,
      .status_out, .quick_stop_req, .drive_state, .status_word, .diagnostic_number,
      .class1_error_diagnostic, .class2_alert_diagnostic, .newest_error_slot,
      .oldest_error_slot, .hist_rd, .last_alert_param);
   master_model u_mst (.clk_sys, .hist_rd, .master_wr, .hist_sel);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Strobe stays high across back-to-back errors, one code per cycle
   task automatic err_burst(input int n, input logic [15:0] base);
      error_detect = 1'b1;
      for (int k = 0; k < n; k++) begin
         error_code = base + 16'(k);
         step(1);
      end
      error_detect = 1'b0;
   endtask
   function automatic logic [31:0] dn(input logic [3:0] lv, input logic [15:0] c);
      return {`DIAG_MFR_SPECIFIC, `DIAG_PROFILE_IO, `DIAG_RESERVED_FIELD, lv, c};
   endfunction

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end

   initial begin
      {nrst, comm_active, sub_active, mgmt_bus_activity, error_detect} = '0;
      {alert_detect, enable_req, fault_reset, quickstop_done} = '0;
      {comm_phase, runc, warn, error_code, alert_code} = '0;
      fsel = {`DIAG_FUNC_WARN, `DIAG_FUNC_FAULT, `DIAG_FUNC_ENABLED, `DIAG_FUNC_READY};
      step(3);
      nrst = 1'b1;
      step(1);
      chk(diagnostic_number, `DIAG_NUM_RESET, "diag reset");
      chk(class1_error_diagnostic, `DIAG_WORD_RESET, "c1 reset");
      chk(class2_alert_diagnostic, `DIAG_WORD_RESET, "c2 reset");
      step(1);
      chk(status_out, 4'h1, "ready out");
      comm_active = 1'b1;
      comm_phase  = 3'h4;
      step(2);
      chk(run_priority, 0, "run idle");
      runc = 7'h01;
      step(2);
      chk(run_priority, 1, "hotplug prio");
      chk(run_hotplug, 1, "hotplug flag");
      for (int i = 1; i < 7; i++) begin
         runc = 7'h7F >> (6 - i);
         step(2);
         chk(run_priority, i + 1, "run rank");
      end
      runc       = '0;
      sub_active = 1'b1;
      enable_req = 1'b1;
      step(2);
      chk(err_priority, 0, "err idle");
      chk(drive_state, diag_pkg::DRV_ENABLED, "enabled");
      chk(status_out, 4'h3, "ready on");
      for (int i = 0; i < 4; i++) begin
         warn = 4'(1 << i);
         step(2);
         chk(status_out[3], 1, "warn on");
      end
      warn = '0;
      step(2);
      chk(status_out[3], 0, "warn off");
      alert_detect = 1'b1;
      alert_code   = 16'h0A5C;
      step(1);
      alert_detect = 1'b0;
      chk(last_alert_param, 16'h0A5C, "alert kept");
      chk(drive_state, diag_pkg::DRV_ENABLED, "alert no trans");
      chk(class2_alert_diagnostic != 0, 1, "c2 flag");
      chk(status_word[13:12], `DIAG_CLASS_ALERT, "alert class");
      chk(diagnostic_number, dn(`DIAG_LEVEL_ALERT, 16'h0), "alert diag");
      err_burst(1, 16'h2300);
      chk(drive_state, diag_pkg::DRV_QUICKSTOP, "qstop");
      chk(quick_stop_req, 1, "qstop req");
      chk(class1_error_diagnostic[0], 1, "c1 flag");
      chk(diagnostic_number, dn(`DIAG_LEVEL_ALARM, 16'h2300), "err diag");
      chk(status_word[13:12], `DIAG_CLASS_ERROR, "err class");
      chk(newest_error_slot, 16'h2300, "newest");
      u_mst.try_write();
      step(1);
      chk(diagnostic_number, dn(`DIAG_LEVEL_ALARM, 16'h2300), "wr ignored");
      quickstop_done = 1'b1;
      step(2);
      quickstop_done = 1'b0;
      chk(drive_state, diag_pkg::DRV_FAULT, "fault");
      chk(quick_stop_req, 0, "qstop drop");
      chk(status_out[2:0], 3'h4, "fault outs");
      chk(err_priority, 1, "err prio");
      err_burst(5, 16'h1001);
      step(1);
      chk(newest_error_slot, 16'h1005, "hist new");
      chk(oldest_error_slot, 16'h1001, "hist old");
      for (int s = 0; s < 5; s++) begin
         u_mst.read_slot(3'(s), v);
         chk(v, 16'h1005 - 16'(s), "hist slot");
      end
      enable_req  = 1'b0;
      fault_reset = 1'b1;
      step(2);
      fault_reset = 1'b0;
      chk(drive_state, diag_pkg::DRV_IDLE, "fault clr");
      chk(diagnostic_number, `DIAG_NUM_RESET, "diag clr");
      chk(class1_error_diagnostic, `DIAG_WORD_RESET, "c1 clr");
      chk(status_out, 4'h1, "ready back");
      for (int a = 0; a < 2; a++) begin
         mgmt_bus_activity = 1'(a);
         step(6);
         tog = 0;
         for (int k = 0; k < 30; k++) begin
            prev = display_point;
            step(1);
            if (display_point !== prev) tog++;
         end
         chk(a ? (tog >= 3) : (tog == 0), 1, "point flash");
      end
      end_sim();
   end
endmodule
